/* File: core/opc_panel_ctrl.sv */
// Operator panel control: manual store/fetch, master clear, switches, lamps
//
// Operation
// - Stopped store plus start writes word to memory
// - Program counter advances after manual store
// - Store and fetch share one manual cycle
// - Read select held off while store held
// - Store suppresses word register reset
// - Master clear only at stop, spares accumulator/word
// - Normalized clear plus inverted copy to bus
// - Data switches force ones, stop only
// - Switches 1-12 to bus, 13 separate
// - Lamps: accumulator running, selection when stopped
// - Accumulator reset presets lamps while running
// - Strobe on bus-to-accum and run; zero clears
// - Stopped: lamps follow register bus directly
// - Lamp 13: overflow or bus bit 13
// - Clear switch resets selected register, stopped only
// - Alteration only stopped; accumulator display when running or selected
// - Accumulator select drives both accumulator transfers
// - PC select: to bus, ybuf loads, back
// - Word select: into word, both halves out
// - Remote start, stop and master clear ORed with local ones
// - Manual fetch runs TF1-TF4 then halts
// - Stop enables panel; run honours start only
`timescale 1ns/100ps
`default_nettype none

module opc_panel_ctrl
   import opc_pkg::*;
#(
   parameter int WORD_W = OPC_WORD_W
) (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Operator panel and remote panel
   input  wire opc_panel_type        panel_in,
   input  wire opc_remote_type       remote_in,
   input  wire logic [12:0]          panel_data_switches,
   output logic      [12:0]          lamps,
   // Processor side inputs
   input  wire logic [WORD_W-1:0]    reg_bus_in,
   input  wire logic                 reg_bus_bit13_in,
   input  wire logic                 add_overflow_flag,
   input  wire logic                 accum_reset_line,
   input  wire logic                 exec_done,
   input  wire logic                 proc_bus_to_accum,
   // Processor side outputs
   output opc_xfer_type              xfer,
   output logic      [WORD_W-1:0]    panel_bus_data,
   output logic                      bus_bit_thirteen,
   output logic                      run_flag,
   output logic                      manual_cycle_req,
   output logic                      memory_read_select,
   output logic                      memory_cycle_start,
   output logic                      pc_increment,
   output logic                      word_reset,
   output logic                      accum_clear,
   output logic                      pc_zeroing,
   output logic                      normalized_master_reset,
   output logic                      io_bus_external_reset_n
);

   // ---------------------------------------------------------------
   // Input synchronizers
   // ---------------------------------------------------------------
   localparam int SYNC_W = $bits(opc_panel_type) + $bits(opc_remote_type) + 13;

   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   opc_panel_type     pnl;
   opc_remote_type    rmt;
   logic [12:0]       dsw;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {panel_in, remote_in, panel_data_switches};
         sync2_reg <= sync1_reg;
      end
   end

   assign {pnl, rmt, dsw} = sync2_reg;

   // ---------------------------------------------------------------
   // Combined controls
   // ---------------------------------------------------------------
   logic stop_mode;
   logic start_lvl;
   logic clr_lvl;
   logic start_prev_reg;
   logic start_edge;
   logic stopped;
   logic [1:0] ctrl_reg;

   assign stop_mode = pnl.stop_sw | rmt.stop_sw;
   assign start_lvl = pnl.start | rmt.start;
   assign clr_lvl   = pnl.master_clr | rmt.master_clr
                      | ctrl_reg[OPC_CTRL_SOFT_CLEAR_BIT];
   // Load is only carried through for the remote's sake
   assign start_edge = start_lvl & ~start_prev_reg;
   assign stopped    = stop_mode & ~run_flag;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_prev_reg <= 1'b0;
      end else begin
         start_prev_reg <= start_lvl;
      end
   end

   // ---------------------------------------------------------------
   // Master clear normalizer
   // ---------------------------------------------------------------
   // One fixed-width pulse per press, however long the switch is held
   logic       clr_armed_reg;
   logic [7:0] norm_cnt_reg;
   logic       norm_active;

   assign norm_active = normalized_master_reset;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_armed_reg           <= 1'b1;
         norm_cnt_reg            <= 8'h00;
         normalized_master_reset <= 1'b0;
         io_bus_external_reset_n <= 1'b1;
      end else begin
         if (!clr_lvl) begin
            clr_armed_reg <= 1'b1;
         end
         if (clr_lvl && clr_armed_reg && stop_mode && !norm_active) begin
            clr_armed_reg           <= 1'b0;
            norm_cnt_reg            <= OPC_NORM_LAST;
            normalized_master_reset <= 1'b1;
            io_bus_external_reset_n <= 1'b0;
         end else if (norm_active) begin
            if (norm_cnt_reg == 8'h00) begin
               normalized_master_reset <= 1'b0;
               io_bus_external_reset_n <= 1'b1;
            end else begin
               norm_cnt_reg <= norm_cnt_reg - 8'h01;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Run flag and manual cycle sequencer
   // ---------------------------------------------------------------
   opc_state_type state_reg;
   logic          store_cycle_reg;
   logic          req_lvl;

   assign req_lvl = stop_mode & (pnl.store | pnl.fetch);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg        <= OPC_IDLE;
         store_cycle_reg  <= 1'b0;
         run_flag         <= 1'b0;
         manual_cycle_req <= 1'b0;
      end else begin
         manual_cycle_req <= req_lvl;
         if (norm_active) begin
            state_reg       <= OPC_IDLE;
            store_cycle_reg <= 1'b0;
            run_flag        <= 1'b0;
         end else begin
            case (state_reg)
               OPC_IDLE: begin
                  if (start_edge && !run_flag) begin
                     run_flag <= 1'b1;
                     if (req_lvl) begin
                        state_reg       <= OPC_TF1;
                        store_cycle_reg <= pnl.store;
                     end
                  end else if (run_flag && stop_mode && exec_done) begin
                     run_flag <= 1'b0;
                  end
               end
               OPC_TF1: state_reg <= OPC_TF2;
               OPC_TF2: state_reg <= OPC_TF3;
               OPC_TF3: state_reg <= OPC_TF4;
               OPC_TF4: begin
                  state_reg       <= OPC_IDLE;
                  run_flag        <= 1'b0;
                  store_cycle_reg <= 1'b0;
               end
               default: state_reg <= OPC_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Memory cycle controls
   // ---------------------------------------------------------------
   logic in_tf1;
   logic in_tf2;
   logic in_tf3;

   assign in_tf1 = (state_reg == OPC_TF1);
   assign in_tf2 = (state_reg == OPC_TF2);
   assign in_tf3 = (state_reg == OPC_TF3);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         memory_read_select <= 1'b0;
         memory_cycle_start <= 1'b0;
         pc_increment       <= 1'b0;
      end else begin
         memory_cycle_start <= in_tf1;
         pc_increment       <= in_tf1;
         if (in_tf1) begin
            memory_read_select <= ~(store_cycle_reg | pnl.store);
         end else if (pnl.store || state_reg == OPC_IDLE) begin
            memory_read_select <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register clear and selection transfers
   // ---------------------------------------------------------------
   logic sel_a;
   logic sel_p;
   logic sel_w;
   logic man_clr;

   assign sel_a   = pnl.sel_a;
   assign sel_p   = pnl.sel_p & ~pnl.sel_a;
   assign sel_w   = pnl.sel_w & ~pnl.sel_a & ~pnl.sel_p;
   assign man_clr = stopped & pnl.clear;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accum_clear <= 1'b0;
         pc_zeroing  <= 1'b0;
         word_reset  <= 1'b0;
      end else begin
         accum_clear <= man_clr & sel_a;
         pc_zeroing  <= (man_clr & sel_p) | norm_active;
         word_reset  <= (man_clr & sel_w)
                        | (in_tf2 & ~store_cycle_reg);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer <= '0;
      end else begin
         xfer.bus_to_accum      <= stopped & sel_a;
         xfer.accum_to_bus      <= stopped & sel_a;
         xfer.pc_to_bus         <= (stopped & sel_p) | in_tf1;
         xfer.ybuf_into_pc      <= stopped & sel_p;
         xfer.bus_to_ybuf_upper <= stopped | in_tf1;
         xfer.bus_to_ybuf_lower <= stopped | in_tf1;
         xfer.bus_to_word_reg   <= stopped & sel_w;
         xfer.word_low_to_bus   <= stopped & sel_w;
         xfer.word_high_to_bus  <= stopped & sel_w;
      end
   end

   // ---------------------------------------------------------------
   // Data switches onto the register bus
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         panel_bus_data   <= '0;
         bus_bit_thirteen <= 1'b0;
      end else begin
         panel_bus_data   <= stopped ? dsw[WORD_W-1:0] : '0;
         bus_bit_thirteen <= stopped & dsw[12];
      end
   end

   // ---------------------------------------------------------------
   // Lamp display
   // ---------------------------------------------------------------
   // Panel bus-to-accum only stands while stopped, so only the processor's strobes
   logic lamp_preset;
   logic lamp_data_strobe;
   logic lamp13_ovf;

   assign lamp_preset      = accum_reset_line & run_flag;
   assign lamp_data_strobe = proc_bus_to_accum & run_flag & ~lamp_preset;
   assign lamp13_ovf       = ~stop_mode | sel_a;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lamps <= OPC_LAMPS_RESET;
      end else if (ctrl_reg[OPC_CTRL_LAMP_TEST_BIT]) begin
         lamps <= '1;
      end else begin
         if (!run_flag) begin
            lamps[WORD_W-1:0] <= reg_bus_in;
         end else if (lamp_preset) begin
            lamps[WORD_W-1:0] <= '1;
         end else if (lamp_data_strobe) begin
            lamps[WORD_W-1:0] <= lamps[WORD_W-1:0] & reg_bus_in;
         end
         lamps[12] <= lamp13_ovf ? add_overflow_flag : reg_bus_bit13_in;
      end
   end

   // ---------------------------------------------------------------
   // APB slave, zero wait states
   // ---------------------------------------------------------------
   logic setup;
   logic mapped;

   assign setup  = psel & ~penable;
   assign mapped = (paddr == OPC_CTRL_OFFSET) | (paddr == OPC_STATUS_OFFSET)
                   | (paddr == OPC_LAMPS_OFFSET);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup && !pwrite) begin
            case (paddr)
               OPC_CTRL_OFFSET:   prdata <= {30'h0, ctrl_reg};
               OPC_STATUS_OFFSET: prdata <= {27'h0, norm_active, store_cycle_reg,
                                             state_reg != OPC_IDLE, stop_mode, run_flag};
               OPC_LAMPS_OFFSET:  prdata <= {19'h0, lamps};
               default:           prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Soft clear self-clears once the normalizer has taken it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= OPC_CTRL_RESET;
      end else if (psel && penable && pready && pwrite && paddr == OPC_CTRL_OFFSET) begin
         ctrl_reg <= pwdata[1:0];
      end else if (norm_active) begin
         ctrl_reg[OPC_CTRL_SOFT_CLEAR_BIT] <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* File: core/opc_pkg.sv */
// Package for the operator panel control block: map, layouts and timing
package opc_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OPC_CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] OPC_STATUS_OFFSET = 8'h04;
   localparam logic [7:0] OPC_LAMPS_OFFSET  = 8'h08;

   // CTRL fields
   localparam int OPC_CTRL_SOFT_CLEAR_BIT = 0;
   localparam int OPC_CTRL_LAMP_TEST_BIT  = 1;
   localparam logic [1:0] OPC_CTRL_RESET  = 2'h0;

   // STATUS fields
   localparam int OPC_STAT_RUN_BIT    = 0;
   localparam int OPC_STAT_STOP_BIT   = 1;
   localparam int OPC_STAT_MANUAL_BIT = 2;
   localparam int OPC_STAT_STORE_BIT  = 3;
   localparam int OPC_STAT_NORM_BIT   = 4;

   // ---------------------------------------------------------------
   // Widths and reset values
   // ---------------------------------------------------------------
   localparam int OPC_WORD_W = 12;
   localparam int OPC_LAMP_W = 13;
   localparam logic [12:0] OPC_LAMPS_RESET = 13'h0000;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int OPC_CLK_MHZ      = 50;
   localparam int OPC_NORM_PULSE_NS = 1000;
   localparam int OPC_NORM_CYCLES  = (OPC_NORM_PULSE_NS * OPC_CLK_MHZ + 999) / 1000;
   localparam logic [7:0] OPC_NORM_LAST = 8'(OPC_NORM_CYCLES - 1);

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic store;
      logic fetch;
      logic start;
      logic stop_sw;
      logic master_clr;
      logic clear;
      logic sel_a;
      logic sel_p;
      logic sel_w;
   } opc_panel_type;

   typedef struct packed {
      logic start;
      logic stop_sw;
      logic load;
      logic master_clr;
   } opc_remote_type;

   typedef struct packed {
      logic bus_to_accum;
      logic accum_to_bus;
      logic pc_to_bus;
      logic ybuf_into_pc;
      logic bus_to_ybuf_upper;
      logic bus_to_ybuf_lower;
      logic bus_to_word_reg;
      logic word_low_to_bus;
      logic word_high_to_bus;
   } opc_xfer_type;

   typedef enum logic [2:0] {
      OPC_IDLE,
      OPC_TF1,
      OPC_TF2,
      OPC_TF3,
      OPC_TF4
   } opc_state_type;

endpackage

/* File: dv/opc_panel_ctrl_assertions.sv */
// Port-level assertions for the operator panel control block
`timescale 1ns/100ps
`default_nettype none
module opc_panel_ctrl_assertions
   import opc_pkg::*;
#(
   parameter int WORD_W = OPC_WORD_W
) (
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // Panel and bus inputs
   input wire opc_panel_type     panel_in,
   input wire opc_remote_type    remote_in,
   input wire logic [WORD_W-1:0] reg_bus_in,
   // Observed outputs
   input wire logic [12:0]       lamps,
   input wire opc_xfer_type      xfer,
   input wire logic              run_flag,
   input wire logic              manual_cycle_req,
   input wire logic              memory_read_select,
   input wire logic              memory_cycle_start,
   input wire logic              pc_increment,
   input wire logic              word_reset,
   input wire logic              normalized_master_reset,
   input wire logic              io_bus_external_reset_n
);
   localparam int NORM = OPC_NORM_CYCLES;
   logic [7:0] norm_cnt;

   // ------
   // Helpers
   // ------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         norm_cnt <= 8'h00;
      end else begin
         norm_cnt <= normalized_master_reset ? norm_cnt + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ------
   // Properties
   // ------
   sequence s_go;
      $rose(run_flag) && manual_cycle_req;
   endsequence
   // Five samples so the synchronizers have settled
   sequence s_idle(logic sel);
      (sel && panel_in.stop_sw && !run_flag) [*5];
   endsequence
   property p_cycle_len;
      s_go |-> run_flag [*4] ##1 !run_flag;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("manual cycle length");
   property p_cycle_mem;
      s_go |=> memory_cycle_start && pc_increment;
   endproperty
   a_cycle_mem: assert property (p_cycle_mem) else $error("no memory start or increment");
   property p_store_noread;
      memory_cycle_start && panel_in.store |-> !memory_read_select;
   endproperty
   a_store_noread: assert property (p_store_noread) else $error("read during store");
   property p_store_keep;
      s_go ##0 panel_in.store |-> !word_reset [*5];
   endproperty
   a_store_keep: assert property (p_store_keep) else $error("word reset during store");
   property p_norm_inv;
      io_bus_external_reset_n != normalized_master_reset;
   endproperty
   a_norm_inv: assert property (p_norm_inv) else $error("bus reset not inverse");
   property p_norm_len;
      $fell(normalized_master_reset) |-> norm_cnt == NORM;
   endproperty
   a_norm_len: assert property (p_norm_len) else $error("normalized pulse length");
   property p_clear_stop;
      $rose(normalized_master_reset) |-> panel_in.stop_sw || remote_in.stop_sw;
   endproperty
   a_clear_stop: assert property (p_clear_stop) else $error("master clear in run");
   property p_sel_a;
      s_idle(panel_in.sel_a) |-> xfer.bus_to_accum && xfer.accum_to_bus;
   endproperty
   a_sel_a: assert property (p_sel_a) else $error("accum select transfers");
   property p_sel_p;
      s_idle(panel_in.sel_p && !panel_in.sel_a) |-> xfer.pc_to_bus && xfer.ybuf_into_pc
         && xfer.bus_to_ybuf_upper && xfer.bus_to_ybuf_lower;
   endproperty
   a_sel_p: assert property (p_sel_p) else $error("pc select transfers");
   property p_sel_w;
      s_idle(panel_in.sel_w && !panel_in.sel_a && !panel_in.sel_p) |-> xfer.bus_to_word_reg
         && xfer.word_low_to_bus && xfer.word_high_to_bus;
   endproperty
   a_sel_w: assert property (p_sel_w) else $error("word select transfers");
   property p_lamp_follow;
      panel_in.stop_sw && $past(panel_in.stop_sw, 4) && !run_flag && !$past(run_flag)
         && !normalized_master_reset && !$past(normalized_master_reset)
         |-> lamps[WORD_W-1:0] == $past(reg_bus_in);
   endproperty
   a_lamp_follow: assert property (p_lamp_follow) else $error("lamps not following bus");
endmodule

bind opc_panel_ctrl opc_panel_ctrl_assertions #(.WORD_W(WORD_W)) opc_panel_ctrl_assertions_i (
   .pclk, .presetn, .panel_in, .remote_in, .reg_bus_in, .lamps, .xfer, .run_flag, .manual_cycle_req,
   .memory_read_select, .memory_cycle_start, .pc_increment, .word_reset, .normalized_master_reset,
   .io_bus_external_reset_n
);
`default_nettype wire

/* File: dv/opc_panel_model.sv */
// Behavioural operator panel: local switches, remote panel, data switches
`timescale 1ns/100ps
`default_nettype none
module opc_panel_model
   import opc_pkg::*;
(
   // Clock
   input  wire logic           pclk,
   // Switch levels
   output var opc_panel_type   panel_in,
   output var opc_remote_type  remote_in,
   output var logic [12:0]     panel_data_switches
);
   initial begin
      panel_in = '0;
      remote_in = '0;
      panel_data_switches = 13'h0000;
   end

   // Levels change just after an edge and hold for n cycles
   task automatic drive(input logic [8:0] p, input logic [3:0] r, input logic [12:0] sw, input int n);
      @(posedge pclk);
      panel_in <= opc_panel_type'(p);
      remote_in <= opc_remote_type'(r);
      panel_data_switches <= sw;
      repeat (n - 1) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking testbench for the operator panel control block
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import opc_pkg::*;
;
   // ------
   // Panel codes and tables
   // ------
   localparam logic [8:0]  STP = 9'h020;
   localparam logic [8:0]  STO = 9'h100;
   localparam logic [8:0]  FET = 9'h080;
   localparam logic [8:0]  STA = 9'h040;
   localparam logic [8:0]  CLR = 9'h008;
   localparam logic [8:0]  SEL [3] = '{9'h004, 9'h002, 9'h001};
   localparam logic [8:0]  MSK [3] = '{9'h180, 9'h078, 9'h007};
   localparam logic [12:0] LMP [3] = '{13'h03c5, 13'h13c5, 13'h13c5};
   localparam int          CIX [3] = '{6, 7, 4};

   logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic           reg_bus_bit13_in, add_overflow_flag, accum_reset_line, exec_done, proc_bus_to_accum;
   logic           bus_bit_thirteen, run_flag, manual_cycle_req, memory_read_select;
   logic           memory_cycle_start, pc_increment, word_reset, accum_clear, pc_zeroing;
   logic           normalized_master_reset, io_bus_external_reset_n;
   logic [7:0]     paddr;
   logic [31:0]    pwdata, prdata, rd;
   logic [12:0]    panel_data_switches, lamps;
   logic [11:0]    reg_bus_in, panel_bus_data;
   opc_panel_type  panel_in;
   opc_remote_type remote_in;
   opc_xfer_type   xfer;
   int             n_mismatch = 0, checks_done = 0;
   int             cnt [8] = '{default: 0};
   int             snap [8];
   wire logic [7:0] mon = {pc_zeroing, accum_clear, normalized_master_reset, word_reset, pc_increment,
                           memory_cycle_start & memory_read_select, memory_cycle_start, run_flag};

   opc_panel_model opc_panel_model_i (.pclk, .panel_in, .remote_in, .panel_data_switches);
   opc_panel_ctrl opc_panel_ctrl_i (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .panel_in,
      .remote_in, .panel_data_switches, .lamps, .reg_bus_in, .reg_bus_bit13_in, .add_overflow_flag,
      .accum_reset_line, .exec_done, .proc_bus_to_accum, .xfer, .panel_bus_data, .bus_bit_thirteen, .run_flag,
      .manual_cycle_req, .memory_read_select, .memory_cycle_start, .pc_increment, .word_reset,
      .accum_clear, .pc_zeroing, .normalized_master_reset, .io_bus_external_reset_n);

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Event counters; tests compare differences between snapshots
   always @(posedge pclk) begin
      for (int i = 0; i < 8; i++) begin
         cnt[i] <= cnt[i] + int'(mon[i] === 1'b1);
      end
   end

   // ------
   // Tasks
   // ------
   function automatic int delta(input int i);
      return cnt[i] - snap[i];
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic pan(input logic [8:0] p, input logic [3:0] r, input int n);
      opc_panel_model_i.drive(p, r, 13'h1a5c, n);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      rd = 'x;
      err = 1'bx;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Tests need about 400 cycles; cut off at 20000
   initial begin
      #400000;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      reg_bus_in = 12'h3c5;
      reg_bus_bit13_in = 1'b1;
      add_overflow_flag = 1'b0;
      accum_reset_line = 1'b0;
      exec_done = 1'b0;
      proc_bus_to_accum = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      pan(STP, 4'h0, 6);
      apb(1'b0, OPC_CTRL_OFFSET, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h0c, 32'hffff_ffff);
      apb(1'b0, 8'h0c, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      for (int k = 0; k < 3; k++) begin
         pan(STP | SEL[k], 4'h0, 8);
         chk(32'(xfer & MSK[k]), 32'(MSK[k]));
         chk(32'(lamps), 32'(LMP[k]));
         chk(32'({bus_bit_thirteen, panel_bus_data}), 32'h1a5c);
         snap = cnt;
         pan(STP | SEL[k] | CLR, 4'h0, 4);
         pan(STP | SEL[k], 4'h0, 6);
         chk(delta(CIX[k]), 32'h4);
      end
      for (int s = 0; s < 2; s++) begin
         pan(STP | (s ? STO : FET), 4'h0, 6);
         snap = cnt;
         pan(STP | STA | (s ? STO : FET), 4'h0, 3);
         pan(STP | (s ? STO : FET), 4'h0, 12);
         chk(delta(0), 32'h4);
         chk(delta(1), 32'h1);
         chk(delta(3), 32'h1);
         chk(delta(2), 32'(1 - s));
         chk(delta(4), 32'(1 - s));
      end
      snap = cnt;
      pan(STP, 4'h1, 3);
      pan(STP, 4'h0, 70);
      chk(delta(5), OPC_NORM_CYCLES);
      snap = cnt;
      apb(1'b1, OPC_CTRL_OFFSET, 32'h1);
      pan(STP, 4'h0, 70);
      chk(delta(5), OPC_NORM_CYCLES);
      snap = cnt;
      pan(9'h000, 4'h0, 6);
      pan(9'h010, 4'h0, 3);
      pan(9'h000, 4'h0, 70);
      chk(delta(5), 32'h0);
      pan(9'h000, 4'h8, 6);
      chk(32'(run_flag), 32'h1);
      snap = cnt;
      pan(SEL[0] | CLR, 4'h0, 6);
      chk(delta(6), 32'h0);
      chk(32'(xfer), 32'h0);
      @(posedge pclk);
      accum_reset_line <= 1'b1;
      add_overflow_flag <= 1'b1;
      @(posedge pclk);
      accum_reset_line <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(lamps), 32'h1fff);
      add_overflow_flag <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(lamps), 32'h0fff);
      proc_bus_to_accum <= 1'b1;
      @(posedge pclk);
      proc_bus_to_accum <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(lamps), 32'h03c5);
      apb(1'b1, OPC_CTRL_OFFSET, 32'h2);
      apb(1'b0, OPC_LAMPS_OFFSET, 32'h0);
      chk(rd, 32'h1fff);
      apb(1'b0, OPC_STATUS_OFFSET, 32'h0);
      chk(rd, 32'h1);
      end_of_test();
   end
endmodule
`default_nettype wire
